// [design/mec_top.sv]
// Mode control unit and clock generation unit with an APB register slave.
//
// Our own choices: the APB interface to the registers and the register addresses.
module mec_top (
	// Clock and reset.
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	// APB slave.
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Clock source ticks: internal RC, crystal, first PLL, second PLL.
	input wire logic [3:0] SRC_TICK_IN,
	// Auxiliary clock ticks.
	output logic [1:0] AUX_TICK_OUT,
	// Oscillator and system settings of the current mode.
	output logic IRC_ON_OUT,
	output logic CRYSTAL_OSCILLATOR_ON_OUT,
	output logic [3:0] SYSCLK_SEL_OUT,
	output logic [1:0] FLASH_MODE_OUT,
	output logic MVR_ON_OUT,
	output logic PAD_OFF_OUT,
	output logic [2:0] PWR_LVL_OUT,
	// First PLL applied settings.
	output logic PLL0_ON_OUT,
	output logic [2:0] PLL0_INPUT_PREDIVIDER_OUT,
	output logic [7:0] PLL0_MFD_OUT,
	output logic [2:0] PLL0_RFD_OUT,
	output logic [5:0] PLL0_RFD2_OUT,
	// Second PLL applied settings.
	output logic PLL1_ON_OUT,
	output logic [2:0] PLL1_INPUT_PREDIVIDER_OUT,
	output logic [7:0] PLL1_MFD_OUT,
	output logic [2:0] PLL1_RFD_OUT,
	// Mode state and peripheral clock enables.
	output logic [3:0] CUR_MODE_OUT,
	output logic MODE_BUSY_OUT,
	output logic [3:0] PERIPH_CLK_EN_OUT
);

	typedef enum logic [1:0] {
		SW_IDLE,
		SW_ARMED,
		SW_SWITCH
	} mec_sw_e;

	// Register storage.
	logic [31:0] mc_r [mec_pkg::NUM_MODES];
	logic [15:0] run_r [mec_pkg::NUM_GROUPS];
	logic [15:0] lp_r [mec_pkg::NUM_GROUPS];
	logic [7:0] pg_r [mec_pkg::NUM_PERIPH];
	logic [1:0] auxsel_r [mec_pkg::NUM_AUX];
	logic [7:0] auxdiv_r [mec_pkg::NUM_AUX];
	logic [31:0] pll0dv_r;
	logic [31:0] pll1dv_r;
	logic [15:0] allow_r;
	logic iconf_r;
	logic [31:0] prdata_r;

	// Mode switch state.
	mec_sw_e sw_r;
	mec_sw_e sw_nxt;
	mec_pkg::mec_mode_e tgt_r;
	mec_pkg::mec_mode_e cur_r;
	logic [31:0] cfg_r;
	logic [3:0] cnt_r;
	logic [3:0] periph_en_r;

	// Bus decode wires.
	logic wr_en;
	logic rd_setup;
	logic aligned;
	logic hit_mc;
	logic hit_run;
	logic hit_lp;
	logic hit_pg;
	logic hit_auxsel;
	logic hit_auxdiv;
	logic hit_fixed;
	logic mapped;
	logic [3:0] mc_idx;
	logic [2:0] grp_idx;
	logic [1:0] pg_idx;
	logic aux_idx;
	logic mc_ok;
	logic [31:0] rd_mux;

	// Mode control decode wires.
	logic mctl_wr;
	logic [15:0] key;
	mec_pkg::mec_mode_e req_tgt;
	logic tgt_allowed;
	logic key2_ok;
	logic switch_done;
	logic iconf_set;
	logic iconf_clr;
	logic pll1_sel;

	// Address decode of the word-aligned register map.
	assign aligned = (PADDR_IN[1:0] == 2'b00);
	assign mc_idx = PADDR_IN[5:2];
	assign grp_idx = PADDR_IN[4:2];
	assign pg_idx = PADDR_IN[3:2];
	assign aux_idx = PADDR_IN[2];
	assign hit_mc = aligned && (PADDR_IN[7:6] == mec_pkg::OFF_MODECFG) &&
		(mc_idx != mec_pkg::MODE_RESET) && (mc_idx <= mec_pkg::MODE_STANDBY);
	assign hit_run = aligned && (PADDR_IN[7:5] == mec_pkg::OFF_RUNGRP);
	assign hit_lp = aligned && (PADDR_IN[7:5] == mec_pkg::OFF_LPGRP);
	assign hit_pg = aligned && (PADDR_IN[7:4] == mec_pkg::OFF_PGSEL);
	assign hit_auxsel = aligned && (PADDR_IN[7:3] == mec_pkg::OFF_AUX_SEL);
	assign hit_auxdiv = aligned && (PADDR_IN[7:3] == mec_pkg::OFF_AUX_DIV);
	assign hit_fixed = (PADDR_IN == mec_pkg::OFF_STATUS) || (PADDR_IN == mec_pkg::OFF_MCTL) ||
		(PADDR_IN == mec_pkg::OFF_ALLOW) || (PADDR_IN == mec_pkg::OFF_ISTAT) ||
		(PADDR_IN == mec_pkg::OFF_PLL0_DV) || (PADDR_IN == mec_pkg::OFF_PLL1_DV);
	assign mapped = hit_fixed || hit_mc || hit_run || hit_lp || hit_pg ||
		hit_auxsel || hit_auxdiv;

	// APB strobes; writes take effect at the access edge, reads latch in setup.
	assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && mapped; // R3
	assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
	assign PRDATA_OUT = prdata_r;

	// Protection check on a mode configuration write.
	assign mc_ok = mec_pkg::mc_valid(PWDATA_IN); // R16 R22

	// Mode control decode: key pair with an allowed, identical target.
	assign mctl_wr = wr_en && (PADDR_IN == mec_pkg::OFF_MCTL);
	assign key = PWDATA_IN[15:0];
	assign req_tgt = mec_pkg::mec_mode_e'(PWDATA_IN[mec_pkg::MCTL_TGT_LSB +: 4]);
	assign tgt_allowed = allow_r[req_tgt] && (req_tgt != mec_pkg::MODE_RESET) &&
		(req_tgt <= mec_pkg::MODE_STANDBY); // R11
	assign key2_ok = (key == mec_pkg::KEY_SECOND) && (req_tgt == tgt_r) && tgt_allowed; // R19
	assign switch_done = (sw_r == SW_SWITCH) && (cnt_r == 4'h0);

	// Invalid-config flag: a new rejection wins over a clear in the same cycle.
	assign iconf_set = wr_en && hit_mc && !mc_ok; // R16
	assign iconf_clr = wr_en && (PADDR_IN == mec_pkg::OFF_ISTAT) &&
		PWDATA_IN[mec_pkg::ISTAT_ICONF]; // R21

	// Read data selection.
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (PADDR_IN == mec_pkg::OFF_STATUS) begin
			rd_mux[mec_pkg::GS_MODE_LSB +: 4] = cur_r; // R20
			rd_mux[mec_pkg::GS_PENDING] = (sw_r == SW_SWITCH);
		end else if (PADDR_IN == mec_pkg::OFF_ALLOW) begin
			rd_mux[15:0] = allow_r;
		end else if (PADDR_IN == mec_pkg::OFF_ISTAT) begin
			rd_mux[mec_pkg::ISTAT_ICONF] = iconf_r;
		end else if (PADDR_IN == mec_pkg::OFF_PLL0_DV) begin
			rd_mux = pll0dv_r;
		end else if (PADDR_IN == mec_pkg::OFF_PLL1_DV) begin
			rd_mux = pll1dv_r;
		end else if (hit_mc) begin
			rd_mux = mc_r[mc_idx];
		end else if (hit_run) begin
			rd_mux[15:0] = run_r[grp_idx];
		end else if (hit_lp) begin
			rd_mux[15:0] = lp_r[grp_idx];
		end else if (hit_pg) begin
			rd_mux[7:0] = pg_r[pg_idx];
		end else if (hit_auxsel) begin
			rd_mux[1:0] = auxsel_r[aux_idx];
		end else if (hit_auxdiv) begin
			rd_mux[7:0] = auxdiv_r[aux_idx];
		end
	end

	// Read data register.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_r <= rd_mux;
		end
	end

	// Mode configuration registers; rejected words are not stored.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			for (int i = 0; i < mec_pkg::NUM_MODES; i++) begin
				mc_r[i] <= mec_pkg::MC_RESET_VAL; // R18
			end
		end else if (wr_en && hit_mc && mc_ok) begin
			mc_r[mc_idx] <= PWDATA_IN; // R12 R2
		end
	end

	// Run and low-power group configuration registers.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			for (int i = 0; i < mec_pkg::NUM_GROUPS; i++) begin
				run_r[i] <= mec_pkg::GRP_RESET;
				lp_r[i] <= mec_pkg::GRP_RESET;
			end
		end else if (wr_en && hit_run) begin
			run_r[grp_idx] <= PWDATA_IN[15:0]; // R14
		end else if (wr_en && hit_lp) begin
			lp_r[grp_idx] <= PWDATA_IN[15:0]; // R15
		end
	end

	// Peripheral group select registers.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			for (int i = 0; i < mec_pkg::NUM_PERIPH; i++) begin
				pg_r[i] <= mec_pkg::PG_RESET;
			end
		end else if (wr_en && hit_pg) begin
			pg_r[pg_idx] <= {1'b0, PWDATA_IN[6:4], 1'b0, PWDATA_IN[2:0]}; // R13
		end
	end

	// Auxiliary clock select and divider registers.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			for (int i = 0; i < mec_pkg::NUM_AUX; i++) begin
				auxsel_r[i] <= mec_pkg::AUX_SEL_RESET; // R18
				auxdiv_r[i] <= mec_pkg::AUX_DIV_RESET;
			end
		end else if (wr_en && hit_auxsel) begin
			auxsel_r[aux_idx] <= PWDATA_IN[1:0]; // R1
		end else if (wr_en && hit_auxdiv) begin
			auxdiv_r[aux_idx] <= PWDATA_IN[7:0]; // R1
		end
	end

	// PLL divider, mode allow and flag registers.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pll0dv_r <= mec_pkg::DV_RESET;
			pll1dv_r <= mec_pkg::DV_RESET;
			allow_r <= mec_pkg::ALLOW_RESET;
			iconf_r <= 1'b0;
		end else begin
			if (wr_en && (PADDR_IN == mec_pkg::OFF_PLL0_DV)) begin
				pll0dv_r <= PWDATA_IN; // R6
			end
			if (wr_en && (PADDR_IN == mec_pkg::OFF_PLL1_DV)) begin
				pll1dv_r <= PWDATA_IN; // R6
			end
			if (wr_en && (PADDR_IN == mec_pkg::OFF_ALLOW)) begin
				allow_r <= PWDATA_IN[15:0] | mec_pkg::ALLOW_FIXED; // R11
			end
			if (iconf_set) begin
				iconf_r <= 1'b1; // R16
			end else if (iconf_clr) begin
				iconf_r <= 1'b0; // R21
			end
		end
	end

	// Next state of the mode switch sequencer.
	always_comb begin
		sw_nxt = sw_r;
		case (sw_r)
			SW_IDLE: begin
				if (mctl_wr && key == mec_pkg::KEY_FIRST) begin
					sw_nxt = SW_ARMED; // R19
				end
			end
			SW_ARMED: begin
				if (mctl_wr && key2_ok) begin
					sw_nxt = SW_SWITCH; // R19 R11
				end else if (mctl_wr && key != mec_pkg::KEY_FIRST) begin
					sw_nxt = SW_IDLE;
				end
			end
			SW_SWITCH: begin
				if (cnt_r == 4'h0) begin
					sw_nxt = SW_IDLE;
				end
			end
			default: begin
				sw_nxt = SW_IDLE;
			end
		endcase
	end

	// Sequencer state, target and switch countdown.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			sw_r <= SW_IDLE;
			tgt_r <= mec_pkg::MODE_DEFAULT_RUN_MODE;
			cnt_r <= 4'h0;
		end else begin
			sw_r <= sw_nxt;
			if (mctl_wr && key == mec_pkg::KEY_FIRST && sw_r != SW_SWITCH) begin
				tgt_r <= req_tgt;
			end
			if (sw_r == SW_ARMED && sw_nxt == SW_SWITCH) begin
				cnt_r <= 4'(mec_pkg::SWITCH_CYCLES - 1);
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end

	// Current mode and its applied configuration change only at switch end.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cur_r <= mec_pkg::MODE_DEFAULT_RUN_MODE; // R4
			cfg_r <= mec_pkg::MC_RESET_VAL; // R18
		end else if (switch_done) begin
			cur_r <= tgt_r; // R17
			cfg_r <= mc_r[tgt_r]; // R9 R12
		end
	end

	// System outputs follow the applied configuration of the current mode.
	assign IRC_ON_OUT = cfg_r[mec_pkg::MC_IRCON];
	assign CRYSTAL_OSCILLATOR_ON_OUT = cfg_r[mec_pkg::MC_CRYSTAL_OSC_ON]; // R2
	assign SYSCLK_SEL_OUT = cfg_r[mec_pkg::MC_SYSCLK_LSB +: 4]; // R22
	assign FLASH_MODE_OUT = cfg_r[mec_pkg::MC_FLASH_LSB +: 2];
	assign MVR_ON_OUT = cfg_r[mec_pkg::MC_MVRON];
	assign PAD_OFF_OUT = cfg_r[mec_pkg::MC_PDO];
	assign PWR_LVL_OUT = cfg_r[mec_pkg::MC_PWR_LSB +: 3];
	assign CUR_MODE_OUT = cur_r;
	assign MODE_BUSY_OUT = (sw_r == SW_SWITCH); // R20

	// First PLL; its secondary output is the second PLL reference.
	mec_pll_ctl u_pll0 (
		.clk_in(CLK_SYS_IN),
		.nrst_in(NRST_IN),
		.apply_in(switch_done),
		.on_req_in(mc_r[tgt_r][mec_pkg::MC_PLL0ON]),
		.dv_in(pll0dv_r),
		.on_out(PLL0_ON_OUT),
		.input_predivider_out(PLL0_INPUT_PREDIVIDER_OUT),
		.mfd_out(PLL0_MFD_OUT),
		.rfd_out(PLL0_RFD_OUT),
		.rfd2_out(PLL0_RFD2_OUT)
	); // R5

	// Second PLL may only run while the first one does.
	assign pll1_sel = mc_r[tgt_r][mec_pkg::MC_PLL1ON] && mc_r[tgt_r][mec_pkg::MC_PLL0ON]; // R5

	// Second PLL, with a single output.
	mec_pll_ctl u_pll1 (
		.clk_in(CLK_SYS_IN),
		.nrst_in(NRST_IN),
		.apply_in(switch_done),
		.on_req_in(pll1_sel),
		.dv_in(pll1dv_r),
		.on_out(PLL1_ON_OUT),
		.input_predivider_out(PLL1_INPUT_PREDIVIDER_OUT),
		.mfd_out(PLL1_MFD_OUT),
		.rfd_out(PLL1_RFD_OUT),
		.rfd2_out()
	);

	// Auxiliary clocks: select a source tick, then divide it.
	for (genvar a = 0; a < mec_pkg::NUM_AUX; a++) begin : g_aux
		mec_clkdiv u_div (
			.clk_in(CLK_SYS_IN),
			.nrst_in(NRST_IN),
			.tick_in(SRC_TICK_IN[auxsel_r[a]]), // R1
			.div_in(auxdiv_r[a]),
			.tick_out(AUX_TICK_OUT[a])
		);
	end

	// Peripheral clock enables from the group of the current mode class.
	for (genvar p = 0; p < mec_pkg::NUM_PERIPH; p++) begin : g_periph
		logic [2:0] rg;
		logic [2:0] lg;
		logic en;
		assign rg = pg_r[p][mec_pkg::PG_RUN_LSB +: 3];
		assign lg = pg_r[p][mec_pkg::PG_LP_LSB +: 3];
		assign en = mec_pkg::mode_running(cur_r) ? run_r[rg][cur_r] : lp_r[lg][cur_r]; // R10 R14 R15
		always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
			if (!NRST_IN) begin
				periph_en_r[p] <= 1'b0;
			end else begin
				periph_en_r[p] <= en;
			end
		end
	end

	assign PERIPH_CLK_EN_OUT = periph_en_r;

endmodule

// [design/mec_pkg.sv]
// Constants, types and helper functions for the mode entry and clock setup block.
// What this block does
// R1 - Each auxiliary clock has a source select register and an output divider register.
// R2 - Crystal enable bit, big-endian position 26 of run config, turns on crystal.
// R3 - Software accesses mode configuration registers only as whole 32-bit words.
// R4 - Leaving reset, the chip always enters the default run mode.
// R5 - First PLL drives its own clock and feeds the second PLL reference.
// R6 - PLL divider registers hold output dividers, input predivider and loop multiplier.
// R7 - Software changes predivider and multiplier only while the PLL is down.
// R8 - New output divider values apply only after a PLL disable and enable.
// R9 - PLL settings take effect at the next mode switch, not on write.
// R10 - Modes are running or not running; reset, run, test, safe are system.
// R11 - Mode allow register gates entry; a disallowed target mode is never entered.
// R12 - Each mode has a config register for power, pads, regulator, flash, clocks.
// R13 - Every peripheral selects one of 8 run and 8 low-power groups.
// R14 - Run group registers give per running mode whether members are clocked.
// R15 - Low-power group registers give per non-running mode whether members are clocked.
// R16 - Mode config writes are checked; a rejected one sets the invalid-config flag.
// R17 - Software reapplies settings by switching into the current mode again.
// R18 - At power-on only the internal oscillator runs and all dividers divide by one.
// R19 - A switch needs target with key 5AF0, then same target with key A50F.
// R20 - Global status shows transition pending and the current mode.
// R21 - Invalid-config flag stays set until software writes one to its bit.
// R22 - System clock select encodes internal oscillator as 0 and crystal as 1.
package mec_pkg;

	// Chip modes, in the order used for per-mode bits and config slots.
	typedef enum logic [3:0] {
		MODE_RESET,
		MODE_TEST,
		MODE_SAFE,
		MODE_DEFAULT_RUN_MODE,
		MODE_USER_RUN_MODE_0,
		MODE_RUN1,
		MODE_RUN2,
		MODE_RUN3,
		MODE_HALT,
		MODE_STOP,
		MODE_STANDBY
	} mec_mode_e;

	// Timing of a mode switch.
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned SWITCH_NS = 500;
	localparam int unsigned SWITCH_CYCLES = (SWITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Sizes of the register groups.
	localparam int unsigned NUM_PERIPH = 4;
	localparam int unsigned NUM_AUX = 2;
	localparam int unsigned NUM_GROUPS = 8;
	localparam int unsigned NUM_MODES = 16;

	// Register byte offsets, and upper address bits of the register blocks.
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_MCTL = 8'h04;
	localparam logic [7:0] OFF_ALLOW = 8'h08;
	localparam logic [7:0] OFF_ISTAT = 8'h0C;
	localparam logic [7:0] OFF_PLL0_DV = 8'h10;
	localparam logic [7:0] OFF_PLL1_DV = 8'h14;
	localparam logic [4:0] OFF_AUX_SEL = 5'h04;
	localparam logic [4:0] OFF_AUX_DIV = 5'h06;
	localparam logic [3:0] OFF_PGSEL = 4'h4;
	localparam logic [1:0] OFF_MODECFG = 2'h2;
	localparam logic [2:0] OFF_RUNGRP = 3'h6;
	localparam logic [2:0] OFF_LPGRP = 3'h7;

	// Mode configuration fields.
	localparam int unsigned MC_SYSCLK_LSB = 0;
	localparam int unsigned MC_IRCON = 4;
	localparam int unsigned MC_CRYSTAL_OSC_ON = 5;
	localparam int unsigned MC_PLL0ON = 6;
	localparam int unsigned MC_PLL1ON = 7;
	localparam int unsigned MC_FLASH_LSB = 16;
	localparam int unsigned MC_MVRON = 20;
	localparam int unsigned MC_PDO = 23;
	localparam int unsigned MC_PWR_LSB = 28;
	localparam logic [31:0] MC_RESET_VAL = 32'h0013_0010;
	localparam logic [3:0] SYSCLK_IRC = 4'h0;
	localparam logic [3:0] SYSCLK_CRYSTAL_OSCILLATOR = 4'h1;
	localparam logic [3:0] SYSCLK_PLL0 = 4'h2;
	localparam logic [3:0] SYSCLK_PLL1 = 4'h3;

	// Mode control and status fields.
	localparam logic [15:0] KEY_FIRST = 16'h5AF0;
	localparam logic [15:0] KEY_SECOND = 16'hA50F;
	localparam int unsigned MCTL_TGT_LSB = 28;
	localparam int unsigned GS_MODE_LSB = 28;
	localparam int unsigned GS_PENDING = 27;
	localparam int unsigned ISTAT_ICONF = 3;
	localparam logic [15:0] ALLOW_RESET = 16'h000F;
	localparam logic [15:0] ALLOW_FIXED = 16'h000F;

	// PLL divider fields and reset values.
	localparam int unsigned DV_MFD_LSB = 0;
	localparam int unsigned DV_INPUT_PREDIVIDER_LSB = 12;
	localparam int unsigned DV_RFD_LSB = 16;
	localparam int unsigned DV_RFD2_LSB = 25;
	localparam logic [31:0] DV_RESET = 32'h0000_0000;

	// Peripheral group select fields and other reset values.
	localparam int unsigned PG_RUN_LSB = 0;
	localparam int unsigned PG_LP_LSB = 4;
	localparam logic [7:0] PG_RESET = 8'h00;
	localparam logic [15:0] GRP_RESET = 16'h0000;
	localparam logic [1:0] AUX_SEL_RESET = 2'h0;
	localparam logic [7:0] AUX_DIV_RESET = 8'h00;

	// True for the running modes.
	function automatic logic mode_running(input logic [3:0] m);
		mode_running = (m == MODE_TEST) || (m == MODE_SAFE) || (m == MODE_DEFAULT_RUN_MODE) ||
			(m == MODE_USER_RUN_MODE_0) || (m == MODE_RUN1) || (m == MODE_RUN2) || (m == MODE_RUN3);
	endfunction

	// True when a mode configuration word passes the protection check.
	function automatic logic mc_valid(input logic [31:0] v);
		logic [3:0] sys;
		sys = v[MC_SYSCLK_LSB +: 4];
		mc_valid = !((sys == SYSCLK_IRC && !v[MC_IRCON]) ||
			(sys == SYSCLK_CRYSTAL_OSCILLATOR && !v[MC_CRYSTAL_OSC_ON]) ||
			(sys == SYSCLK_PLL0 && !v[MC_PLL0ON]) ||
			(sys == SYSCLK_PLL1 && !v[MC_PLL1ON]) ||
			(sys > SYSCLK_PLL1) ||
			(v[MC_PLL1ON] && !v[MC_PLL0ON]));
	endfunction

endpackage

// [design/mec_clkdiv.sv]
// Auxiliary clock output divider that thins a source tick stream.
module mec_clkdiv (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic nrst_in,
	// Source tick and divide value, zero dividing by one.
	input wire logic tick_in,
	input wire logic [7:0] div_in,
	// Divided tick.
	output logic tick_out
);

	logic [7:0] cnt_r;
	logic wrap;

	// Wrap when the count reaches the programmed value.
	assign wrap = (cnt_r >= div_in);

	// Count source ticks and pass every (div+1)-th one.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_r <= 8'h00;
			tick_out <= 1'b0;
		end else begin
			tick_out <= tick_in && wrap;
			if (tick_in) begin
				cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
			end
		end
	end

endmodule

// [design/mec_pll_ctl.sv]
// Applied settings of one PLL, loaded from its divider register at a mode switch.
module mec_pll_ctl (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic nrst_in,
	// Mode switch pulse, requested power state and programmed dividers.
	input wire logic apply_in,
	input wire logic on_req_in,
	input wire logic [31:0] dv_in,
	// Applied state.
	output logic on_out,
	output logic [2:0] input_predivider_out,
	output logic [7:0] mfd_out,
	output logic [2:0] rfd_out,
	output logic [5:0] rfd2_out
);

	logic load;

	// Dividers load only as the PLL goes from off to on at a switch.
	assign load = apply_in && on_req_in && !on_out; // R8 R9

	// Power state follows the new mode; an already running PLL keeps its dividers.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			on_out <= 1'b0;
			input_predivider_out <= 3'h0;
			mfd_out <= 8'h00;
			rfd_out <= 3'h0;
			rfd2_out <= 6'h00;
		end else begin
			if (apply_in) begin
				on_out <= on_req_in; // R9
			end
			if (load) begin
				input_predivider_out <= dv_in[mec_pkg::DV_INPUT_PREDIVIDER_LSB +: 3]; // R6
				mfd_out <= dv_in[mec_pkg::DV_MFD_LSB +: 8];
				rfd_out <= dv_in[mec_pkg::DV_RFD_LSB +: 3];
				rfd2_out <= dv_in[mec_pkg::DV_RFD2_LSB +: 6];
			end
		end
	end

endmodule

// [testbench/mec_monitor.sv]
// Port-level assertions for the mode entry and clock setup block.
module mec_monitor (
	// Clock, reset and bus.
	input wire logic CLK_SYS_IN,
	input wire logic NRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic PSLVERR_OUT,
	// Applied settings and mode state.
	input wire logic IRC_ON_OUT,
	input wire logic CRYSTAL_OSCILLATOR_ON_OUT,
	input wire logic [3:0] SYSCLK_SEL_OUT,
	input wire logic PLL0_ON_OUT,
	input wire logic [7:0] PLL0_MFD_OUT,
	input wire logic PLL1_ON_OUT,
	input wire logic [3:0] CUR_MODE_OUT,
	input wire logic MODE_BUSY_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!NRST_IN);
	logic key_seen_r;
	wire key_seen_nxt = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 8'h04
		&& PWDATA_IN[15:0] == 16'hA50F;
	// Remembers that the inverted key was written at the previous edge.
	always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			key_seen_r <= 1'b0;
		end else begin
			key_seen_r <= key_seen_nxt;
		end
	end
	// A switch holds busy for five cycles, then drops it.
	sequence busy_s;
		MODE_BUSY_OUT [*5] ##1 !MODE_BUSY_OUT;
	endsequence
	reset_exit_a: assert property ($rose(NRST_IN) |-> CUR_MODE_OUT == 4'h3
		&& IRC_ON_OUT && !CRYSTAL_OSCILLATOR_ON_OUT && SYSCLK_SEL_OUT == 4'h0) else $error("bad reset exit");
	busy_len_a: assert property ($rose(MODE_BUSY_OUT) |-> busy_s) else $error("busy length");
	key_start_a: assert property ($rose(MODE_BUSY_OUT) |-> key_seen_r) else $error("no key");
	switch_only_a: assert property (!$fell(MODE_BUSY_OUT) |-> $stable(CUR_MODE_OUT)
		&& $stable(CRYSTAL_OSCILLATOR_ON_OUT) && $stable(PLL0_ON_OUT)) else $error("early change");
	mode_range_a: assert property (CUR_MODE_OUT != 4'h0 && CUR_MODE_OUT <= 4'hA)
		else $error("bad mode");
	sysclk_ok_a: assert property (SYSCLK_SEL_OUT <= 4'h3 && (SYSCLK_SEL_OUT != 4'h0
		|| IRC_ON_OUT) && (SYSCLK_SEL_OUT != 4'h1 || CRYSTAL_OSCILLATOR_ON_OUT)) else $error("bad clock");
	pll_chain_a: assert property (PLL1_ON_OUT |-> PLL0_ON_OUT) else $error("pll order");
	div_hold_a: assert property ($changed(PLL0_MFD_OUT) |-> $rose(PLL0_ON_OUT))
		else $error("divider moved");
	word_only_a: assert property (PSEL_IN && PENABLE_IN && PADDR_IN[1:0] != 2'h0
		|-> PSLVERR_OUT) else $error("unaligned taken");
endmodule

bind mec_top mec_monitor mec_monitor_inst (.CLK_SYS_IN, .NRST_IN, .PSEL_IN, .PENABLE_IN,
	.PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PSLVERR_OUT, .IRC_ON_OUT, .CRYSTAL_OSCILLATOR_ON_OUT,
	.SYSCLK_SEL_OUT, .PLL0_ON_OUT, .PLL0_MFD_OUT, .PLL1_ON_OUT, .CUR_MODE_OUT, .MODE_BUSY_OUT);

// [testbench/testbench.sv]
// Self-checking bench for the mode entry and clock setup block.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, crystal_oscillator, pll0_on, busy, e, mvr;
	logic [7:0] paddr, loop_multiplier;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] src, cur_mode, pen;
	logic [2:0] input_predivider, rfd;
	logic [1:0] aux, flash;
	int fails, check_count, cycles, aux_cnt;
	mec_top mec_top_inst (.CLK_SYS_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SRC_TICK_IN(src),
		.AUX_TICK_OUT(aux), .IRC_ON_OUT(), .CRYSTAL_OSCILLATOR_ON_OUT(crystal_oscillator), .SYSCLK_SEL_OUT(),
		.FLASH_MODE_OUT(flash), .MVR_ON_OUT(mvr), .PAD_OFF_OUT(), .PWR_LVL_OUT(),
		.PLL0_ON_OUT(pll0_on), .PLL0_INPUT_PREDIVIDER_OUT(input_predivider), .PLL0_MFD_OUT(loop_multiplier),
		.PLL0_RFD_OUT(rfd), .PLL0_RFD2_OUT(), .PLL1_ON_OUT(), .PLL1_INPUT_PREDIVIDER_OUT(),
		.PLL1_MFD_OUT(), .PLL1_RFD_OUT(), .CUR_MODE_OUT(cur_mode), .MODE_BUSY_OUT(busy),
		.PERIPH_CLK_EN_OUT(pen));
	// Clock, cycle ceiling and divided tick counter.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		aux_cnt += (aux[0] === 1'b1);
		if (cycles == 3000) begin
			fails++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	// One bus transfer: setup, access until ready, then one idle edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check($sformatf("register %h", a), exp, q);
	endtask
	// Key pair for a switch, then wait for busy to come and go.
	task automatic go(input logic [3:0] m);
		apb(1'b1, 8'h04, {m, 12'h000, 16'h5AF0});
		apb(1'b1, 8'h04, {m, 12'h000, 16'hA50F});
		for (int n = 0; n < 3 && busy !== 1'b1; n++) @(negedge clk);
		for (int n = 0; n < 9 && busy !== 1'b0; n++) @(negedge clk);
		@(posedge clk);
	endtask
	// Main sequence.
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		src = 4'h1;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		check("mode", 4'h3, cur_mode);
		rd(8'h00, 32'h3000_0000);
		rd(8'h8C, 32'h0013_0010);
		check("flash and regulator", 3'h7, {flash, mvr});
		apb(1'b0, 8'h0D, 32'h0);
		check("error", 1'b1, e);
		apb(1'b1, 8'h8C, 32'h0013_0011);
		rd(8'h8C, 32'h0013_0010);
		rd(8'h0C, 32'h8);
		apb(1'b1, 8'h0C, 32'h0);
		rd(8'h0C, 32'h8);
		apb(1'b1, 8'h0C, 32'h8);
		rd(8'h0C, 32'h0);
		apb(1'b1, 8'h8C, 32'h0013_0030);
		check("crystal early", 1'b0, crystal_oscillator);
		go(4'h3);
		check("crystal", 1'b1, crystal_oscillator);
		apb(1'b1, 8'h10, 32'h0002_1020);
		apb(1'b1, 8'h90, 32'h0013_0050);
		apb(1'b1, 8'h08, 32'h0);
		rd(8'h08, 32'hF);
		go(4'h4);
		check("blocked mode", 4'h3, cur_mode);
		apb(1'b1, 8'h08, 32'h10);
		go(4'h4);
		check("run mode", 4'h4, cur_mode);
		check("pll", {1'b1, 3'h1, 3'h2, 8'h20}, {1'b1, input_predivider, rfd, loop_multiplier});
		check("pll on", 1'b1, pll0_on);
		apb(1'b1, 8'h10, 32'h0003_1020);
		go(4'h4);
		check("divider", {3'h2, 8'h20}, {rfd, loop_multiplier});
		apb(1'b1, 8'h04, {4'h3, 12'h000, 16'hA50F});
		repeat (8) @(posedge clk);
		check("lone key", 4'h4, cur_mode);
		apb(1'b1, 8'h40, 32'h1);
		apb(1'b1, 8'hC4, 32'h10);
		@(posedge clk);
		check("periph", 4'h1, pen);
		apb(1'b1, 8'h30, 32'h1);
		aux_cnt = 0;
		repeat (40) @(posedge clk);
		check("aux halved", 1'b1, aux_cnt >= 19 && aux_cnt <= 21);
		apb(1'b1, 8'h20, 32'h1);
		aux_cnt = 0;
		repeat (40) @(posedge clk);
		check("aux idle", 1'b1, aux_cnt <= 1);
		conclude();
	end
endmodule
